// File: core/mac_top.sv
// Notes on behaviour
// RULE_01: multiply two 12-bit operands into a full 24-bit product.
// RULE_02: 27-bit accumulator; product sign- or zero-extended by operand mode.
// RULE_03: A register loads on A clock rise, B register on B clock rise.
// RULE_04: round, signed, sum, difference captured on rise of A-or-B clock.
// RULE_05: signed control high means two's complement, low means unsigned.
// RULE_06: rounding adds one at bit 11 of the product.
// RULE_07: accumulator updates only on rising edge of result clock.
// RULE_08: sum high, difference low: accumulator becomes product plus old sum.
// RULE_09: both high: accumulator becomes product minus old sum.
// RULE_10: sum low: product loaded directly, difference ignored.
// RULE_11: three sections: 12-bit low, 12-bit middle, 3-bit extension.
// RULE_12: each section has its own active-low output enable.
// RULE_13: no preload: enabled sections drive pins, others float.
// RULE_14: preload: all pins float; only disabled sections take pin data.
// RULE_15: preload data captured from pins on result clock rise.
// RULE_16: host holds preload and section enable high, drives pins across edge.
// RULE_17: preload uses the same bidirectional result pins.
// RULE_18: accumulator order is extension, middle, low from top down.
// RULE_19: preloaded sections take pin data instead of arithmetic result.
`timescale 1ns/10ps
`default_nettype none
module mac_top
  import mac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_a_pin,
  input wire logic clk_b_pin,
  input wire logic clk_r_pin,
  input wire logic [11:0] a_pin,
  input wire logic [11:0] b_pin,
  input wire logic round_enable,
  input wire logic signed_operands,
  input wire logic sum_enable,
  input wire logic sub_enable,
  input wire logic load_from_pins,
  input wire logic ext_drive_disable,
  input wire logic mid_drive_disable,
  input wire logic low_drive_disable,
  input wire logic [11:0] result_low_part_i,
  input wire logic [11:0] result_mid_part_i,
  input wire logic [2:0] result_ext_part_i,
  output logic [11:0] result_low_part_o,
  output logic [11:0] result_mid_part_o,
  output logic [2:0] result_ext_part_o,
  output logic result_low_part_oe,
  output logic result_mid_part_oe,
  output logic result_ext_part_oe
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int SYW = 3 + 12 + 12 + 4 + 4 + 27;
  logic [SYW-1:0] raw_in;
  logic [SYW-1:0] syn_in;
  assign raw_in = {clk_a_pin, clk_b_pin, clk_r_pin, a_pin, b_pin,
                   round_enable, signed_operands, sum_enable, sub_enable,
                   load_from_pins, ext_drive_disable, mid_drive_disable,
                   low_drive_disable, result_ext_part_i, result_mid_part_i,
                   result_low_part_i};
  mac_sync2 #(.W(SYW)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(raw_in),
    .q(syn_in)
  );
  logic ca_s, cb_s, cr_s;
  logic [11:0] a_s, b_s;
  logic rnd_s, sgn_s, sum_s, sub_s;
  logic pre_s, xdis_s, mdis_s, ldis_s;
  logic [26:0] pins_s;
  assign {ca_s, cb_s, cr_s, a_s, b_s, rnd_s, sgn_s, sum_s, sub_s,
          pre_s, xdis_s, mdis_s, ldis_s, pins_s} = syn_in;

  // ----------------------------------------------------------------
  // clock edge detection
  // ----------------------------------------------------------------
  logic ca_q, cb_q, cr_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ca_q <= 1'b0;
      cb_q <= 1'b0;
      cr_q <= 1'b0;
    end else begin
      ca_q <= ca_s;
      cb_q <= cb_s;
      cr_q <= cr_s;
    end
  end
  logic a_rise, b_rise, ab_rise, r_rise;
  assign a_rise = ca_s & ~ca_q;
  assign b_rise = cb_s & ~cb_q;
  // or of both clocks rises only when it was low before
  assign ab_rise = (ca_s | cb_s) & ~(ca_q | cb_q);
  assign r_rise = cr_s & ~cr_q;

  // ----------------------------------------------------------------
  // operand and control registers
  // ----------------------------------------------------------------
  logic [11:0] a_q, b_q;
  logic rnd_q, sgn_q, sum_q, sub_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      a_q <= MAC_OP_RST;
    end else if (a_rise) begin
      a_q <= a_s; // RULE_03
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      b_q <= MAC_OP_RST;
    end else if (b_rise) begin
      b_q <= b_s; // RULE_03
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rnd_q <= 1'b0;
      sgn_q <= 1'b0;
      sum_q <= 1'b0;
      sub_q <= 1'b0;
    end else if (ab_rise) begin
      rnd_q <= rnd_s; // RULE_04
      sgn_q <= sgn_s;
      sum_q <= sum_s;
      sub_q <= sub_s;
    end
  end

  // ----------------------------------------------------------------
  // multiplier
  // ----------------------------------------------------------------
  logic signed [12:0] a_ext, b_ext;
  logic signed [25:0] prod_full;
  logic [23:0] prod;
  logic [23:0] prod_rnd;
  logic [26:0] prod_x;
  // RULE_05
  assign a_ext = {sgn_q & a_q[11], a_q};
  assign b_ext = {sgn_q & b_q[11], b_q};
  assign prod_full = a_ext * b_ext;
  assign prod = prod_full[23:0]; // RULE_01
  // RULE_06
  localparam logic [23:0] RND_ONE = 24'h000001 << MAC_RND_BIT;
  assign prod_rnd = prod + (rnd_q ? RND_ONE : 24'h000000);
  // RULE_02
  assign prod_x = {{3{sgn_q & prod_rnd[23]}}, prod_rnd};

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  logic [26:0] acc_q;
  logic [26:0] arith;
  mac_op_t op;
  always_comb begin
    if (!sum_q) begin
      op = MAC_OP_LOAD;
    end else if (sub_q) begin
      op = MAC_OP_SUB;
    end else begin
      op = MAC_OP_ADD;
    end
  end
  always_comb begin
    case (op)
      MAC_OP_ADD: arith = prod_x + acc_q; // RULE_08
      MAC_OP_SUB: arith = prod_x - acc_q; // RULE_09
      MAC_OP_LOAD: arith = prod_x; // RULE_10
      default: arith = prod_x;
    endcase
  end
  logic [26:0] pre_mask;
  // RULE_14 RULE_19
  assign pre_mask = pre_s ? {{MAC_EXT_W{xdis_s}}, {MAC_MID_W{mdis_s}},
                             {MAC_LOW_W{ldis_s}}} : 27'h0000000;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= MAC_ACC_RST;
    end else if (r_rise) begin
      // RULE_07 RULE_15 RULE_17 RULE_19
      acc_q <= (pins_s & pre_mask) | (arith & ~pre_mask);
    end
  end

  // ----------------------------------------------------------------
  // section outputs
  // ----------------------------------------------------------------
  // RULE_11 RULE_18
  assign result_low_part_o = acc_q[MAC_LOW_LSB +: MAC_LOW_W];
  assign result_mid_part_o = acc_q[MAC_MID_LSB +: MAC_MID_W];
  assign result_ext_part_o = acc_q[MAC_EXT_LSB +: MAC_EXT_W];
  // RULE_12 RULE_13 RULE_14
  assign result_low_part_oe = ~pre_s & ~ldis_s;
  assign result_mid_part_oe = ~pre_s & ~mdis_s;
  assign result_ext_part_oe = ~pre_s & ~xdis_s;

  // ----------------------------------------------------------------
  // reference values for the checks
  // ----------------------------------------------------------------
  // operands widened by hand so the products stand apart from the design
  logic [23:0] ref_uns;
  logic [23:0] ref_sgn;
  assign ref_uns = {12'h000, a_q} * {12'h000, b_q};
  assign ref_sgn = {{12{a_q[11]}}, a_q} * {{12{b_q[11]}}, b_q};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_acc_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    !r_rise |=> $stable(acc_q))
    else $error("accumulator changed without result clock");
  a_a_capture: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    a_rise |=> a_q == $past(a_s))
    else $error("operand a not captured");
  a_ctl_capture: assert property (@(posedge clk) // RULE_04
    disable iff (!rst_n)
    ab_rise |=> sum_q == $past(sum_s) && sub_q == $past(sub_s))
    else $error("controls not captured");
  a_load_op: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
    r_rise && !pre_s && !sum_q |=> acc_q == $past(prod_x))
    else $error("load did not store product");
  a_add_op: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    r_rise && !pre_s && sum_q && !sub_q
      |=> acc_q == 27'($past(prod_x) + $past(acc_q)))
    else $error("add result wrong");
  a_sub_op: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    r_rise && !pre_s && sum_q && sub_q
      |=> acc_q == 27'($past(prod_x) - $past(acc_q)))
    else $error("subtract result wrong");
  a_pre_float: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
    pre_s |-> !result_low_part_oe && !result_mid_part_oe
              && !result_ext_part_oe)
    else $error("pins driven during preload");
  a_pre_low: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
    r_rise && pre_s && ldis_s |=> result_low_part_o == $past(pins_s[11:0]))
    else $error("low section preload lost");
  a_drive_low: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    result_low_part_oe == (!pre_s && !ldis_s))
    else $error("low section drive wrong");
  a_unsigned_prod: assert property (@(posedge clk) // RULE_05
    disable iff (!rst_n)
    !sgn_q |-> prod == ref_uns)
    else $error("unsigned product wrong");
  // ----------------------------------------------------------------
  // capture checks
  // ----------------------------------------------------------------
  a_b_capture: assert property (@(posedge clk) // RULE_03
    disable iff (!rst_n)
    b_rise |=> b_q == $past(b_s))
    else $error("operand b not captured");
  a_a_hold: assert property (@(posedge clk) // RULE_03
    disable iff (!rst_n)
    !a_rise |=> $stable(a_q))
    else $error("operand a changed without its clock");
  a_b_hold: assert property (@(posedge clk) // RULE_03
    disable iff (!rst_n)
    !b_rise |=> $stable(b_q))
    else $error("operand b changed without its clock");
  a_mode_capture: assert property (@(posedge clk) // RULE_04
    disable iff (!rst_n)
    ab_rise |=> rnd_q == $past(rnd_s) && sgn_q == $past(sgn_s))
    else $error("round or signed control not captured");
  a_ctl_hold: assert property (@(posedge clk) // RULE_04
    disable iff (!rst_n)
    !ab_rise |=> $stable({rnd_q, sgn_q, sum_q, sub_q}))
    else $error("controls changed without operand clock");
  // ----------------------------------------------------------------
  // product checks
  // ----------------------------------------------------------------
  a_signed_prod: assert property (@(posedge clk) // RULE_05
    disable iff (!rst_n)
    sgn_q |-> prod == ref_sgn)
    else $error("signed product wrong");
  a_round_half: assert property (@(posedge clk) // RULE_06
    disable iff (!rst_n)
    rnd_q |-> prod_rnd[23:12] == prod[23:12] + {11'h000, prod[11]})
    else $error("rounded upper half wrong");
  a_no_round: assert property (@(posedge clk) // RULE_06
    disable iff (!rst_n)
    !rnd_q |-> prod_rnd == prod)
    else $error("product altered without rounding");
  a_sign_ext: assert property (@(posedge clk) // RULE_02
    disable iff (!rst_n)
    sgn_q |-> prod_x == {{3{prod_rnd[23]}}, prod_rnd})
    else $error("signed product not sign extended");
  a_zero_ext: assert property (@(posedge clk) // RULE_02
    disable iff (!rst_n)
    !sgn_q |-> prod_x == {3'h0, prod_rnd})
    else $error("unsigned product not zero extended");
  // ----------------------------------------------------------------
  // accumulator checks
  // ----------------------------------------------------------------
  a_load_sub_set: assert property (@(posedge clk) // RULE_10
    disable iff (!rst_n)
    r_rise && !pre_s && !sum_q && sub_q |=> acc_q == $past(prod_x))
    else $error("load affected by difference control");
  a_plain_update: assert property (@(posedge clk) // RULE_14
    disable iff (!rst_n)
    r_rise && !pre_s |=> acc_q == $past(arith))
    else $error("pin data taken without preload");
  a_pre_mid: assert property (@(posedge clk) // RULE_15
    disable iff (!rst_n)
    r_rise && pre_s && mdis_s |=> result_mid_part_o == $past(pins_s[23:12]))
    else $error("middle section preload lost");
  a_pre_ext: assert property (@(posedge clk) // RULE_15
    disable iff (!rst_n)
    r_rise && pre_s && xdis_s |=> result_ext_part_o == $past(pins_s[26:24]))
    else $error("extension section preload lost");
  a_keep_low: assert property (@(posedge clk) // RULE_19
    disable iff (!rst_n)
    r_rise && pre_s && !ldis_s |=> result_low_part_o == $past(arith[11:0]))
    else $error("unselected low section took pin data");
  a_keep_mid: assert property (@(posedge clk) // RULE_19
    disable iff (!rst_n)
    r_rise && pre_s && !mdis_s |=> result_mid_part_o == $past(arith[23:12]))
    else $error("unselected middle section took pin data");
  a_keep_ext: assert property (@(posedge clk) // RULE_19
    disable iff (!rst_n)
    r_rise && pre_s && !xdis_s |=> result_ext_part_o == $past(arith[26:24]))
    else $error("unselected extension section took pin data");
  // ----------------------------------------------------------------
  // output enable checks
  // ----------------------------------------------------------------
  a_drive_mid: assert property (@(posedge clk) // RULE_13
    disable iff (!rst_n)
    result_mid_part_oe == (!pre_s && !mdis_s))
    else $error("middle section drive wrong");
  a_drive_ext: assert property (@(posedge clk) // RULE_13
    disable iff (!rst_n)
    result_ext_part_oe == (!pre_s && !xdis_s))
    else $error("extension section drive wrong");
  a_own_enable: assert property (@(posedge clk) // RULE_12
    disable iff (!rst_n)
    !pre_s && !ldis_s && mdis_s && xdis_s |-> result_low_part_oe
      && !result_mid_part_oe && !result_ext_part_oe)
    else $error("section enables not independent");
  c_add: cover property (@(posedge clk) disable iff (!rst_n)
    r_rise && sum_q && !sub_q && !pre_s);
  c_sub: cover property (@(posedge clk) disable iff (!rst_n)
    r_rise && sum_q && sub_q && !pre_s);
  c_preload: cover property (@(posedge clk) disable iff (!rst_n)
    r_rise && pre_s && xdis_s && !ldis_s);
  c_round: cover property (@(posedge clk) disable iff (!rst_n)
    r_rise && rnd_q && sgn_q);
  c_load: cover property (@(posedge clk) disable iff (!rst_n)
    r_rise && !sum_q && !pre_s);
endmodule : mac_top
`default_nettype wire

// File: core/mac_pkg.sv
package mac_pkg;
  localparam int MAC_OP_W = 12;
  localparam int MAC_PROD_W = 24;
  localparam int MAC_ACC_W = 27;
  localparam int MAC_LOW_W = 12;
  localparam int MAC_MID_W = 12;
  localparam int MAC_EXT_W = 3;
  localparam int MAC_LOW_LSB = 0;
  localparam int MAC_MID_LSB = 12;
  localparam int MAC_EXT_LSB = 24;
  localparam int MAC_RND_BIT = 11;
  localparam logic [26:0] MAC_ACC_RST = 27'h0000000;
  localparam logic [11:0] MAC_OP_RST = 12'h000;
  typedef enum logic [1:0] {
    MAC_OP_LOAD = 2'b00,
    MAC_OP_ADD = 2'b01,
    MAC_OP_SUB = 2'b10
  } mac_op_t;
endpackage : mac_pkg

// File: core/mac_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module mac_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : mac_sync2
`default_nettype wire

// File: test/mac_host_pins.sv
`timescale 1ns/10ps
`default_nettype none
module mac_host_pins (
  input wire logic clk,
  input wire logic [26:0] dut_o,
  input wire logic [2:0] dut_oe,
  input wire logic [26:0] host_val,
  input wire logic [2:0] host_en,
  output logic [26:0] pin_i
);
  logic [26:0] last_q = '0;
  logic [26:0] dm;
  logic [26:0] hm;
  assign dm = {{3{dut_oe[2]}}, {12{dut_oe[1]}}, {12{dut_oe[0]}}};
  // host waits until the block has let go of a section
  assign hm = {{3{host_en[2]}}, {12{host_en[1]}}, {12{host_en[0]}}} & ~dm;
  // --------------------------------------
  // undriven pins toggle, never hold value
  // --------------------------------------
  assign pin_i = (dut_o & dm) | (host_val & hm)
                 | (~last_q & ~(dm | hm));
  always @(posedge clk) begin
    last_q <= pin_i;
  end
endmodule : mac_host_pins
`default_nettype wire

// File: test/mac12_accumulate_preload_bench.sv
`timescale 1ns/10ps
`default_nettype none
module mac12_accumulate_preload_bench;
  import mac_pkg::*;
  logic clk, rst_n, ca, cb, cr, rnd, sgn, sm, sb, pre, dx, dm, dl;
  logic [11:0] a, b, li, mi, lo, mo;
  logic [2:0] xi, xo, oe, hen;
  logic [26:0] hval, pins, acc;
  int seed = 83301;
  int fail_count = 0;
  int total_checks = 0;
  mac_top i_dut (.clk(clk), .rst_n(rst_n), .clk_a_pin(ca), .clk_b_pin(cb),
    .clk_r_pin(cr), .a_pin(a), .b_pin(b), .round_enable(rnd),
    .signed_operands(sgn), .sum_enable(sm), .sub_enable(sb),
    .load_from_pins(pre), .ext_drive_disable(dx), .mid_drive_disable(dm),
    .low_drive_disable(dl), .result_low_part_i(li), .result_mid_part_i(mi),
    .result_ext_part_i(xi), .result_low_part_o(lo), .result_mid_part_o(mo),
    .result_ext_part_o(xo), .result_low_part_oe(oe[0]),
    .result_mid_part_oe(oe[1]), .result_ext_part_oe(oe[2]));
  mac_host_pins i_host (.clk(clk), .dut_o({xo, mo, lo}), .dut_oe(oe),
    .host_val(hval), .host_en(hen), .pin_i(pins));
  assign {xi, mi, li} = pins;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [26:0] got, input logic [26:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  function automatic logic [26:0] arith(input logic [11:0] x, y,
      input logic [3:0] c, input logic [26:0] old);
    logic signed [23:0] sx, sy;
    logic [23:0] p;
    logic [26:0] e;
    sx = c[2] ? {{12{x[11]}}, x} : {12'h000, x};
    sy = c[2] ? {{12{y[11]}}, y} : {12'h000, y};
    p = sx * sy + (c[3] ? 24'h000800 : 24'h000000);
    e = c[2] ? {{3{p[23]}}, p} : {3'h0, p};
    return !c[1] ? e : (c[0] ? e - old : e + old);
  endfunction : arith
  // ---------------------------------------
  // one A/B load then one result clock
  // ---------------------------------------
  task automatic op(input logic [11:0] x, y, input logic [3:0] c,
      input logic [2:0] d, input logic p, input logic [26:0] v);
    logic [26:0] m;
    {rnd, sgn, sm, sb} = c;
    a = x;
    b = y;
    {dx, dm, dl} = d;
    pre = p;
    hval = v;
    hen = p ? d : 3'h0;
    cyc(3);
    ca = 1'b1;
    cb = 1'b1;
    cyc(3);
    {ca, cb, a, b, rnd, sgn, sm, sb} = {2'b00, ~x, ~y, ~c};
    cyc(2);
    chk({xo, mo, lo}, acc);
    chk({24'h0, oe}, {24'h0, p ? 3'h0 : ~d});
    cr = 1'b1;
    cyc(3);
    cr = 1'b0;
    cyc(5);
    m = {{3{d[2]}}, {12{d[1]}}, {12{d[0]}}} & {27{p}};
    acc = (arith(x, y, c, acc) & ~m) | (v & m);
    chk({xo, mo, lo}, acc);
    chk({3'h0, mo, lo}, {3'h0, acc[23:0]});
    chk({24'h0, xo}, {24'h0, acc[26:24]});
    chk({15'h0, lo}, {15'h0, acc[11:0]});
  endtask : op
  initial begin
    logic [31:0] r1, r2, r3;
    {ca, cb, cr, rnd, sgn, sm, sb, pre, dx, dm, dl} = 11'h000;
    {a, b, hen, hval, acc} = 81'h0;
    rst_n = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    cyc(3);
    op(12'h800, 12'h800, 4'h4, 3'h0, 1'b0, 27'h0);
    op(12'hFFF, 12'hFFF, 4'h0, 3'h7, 1'b0, 27'h0);
    op(12'h7FF, 12'h800, 4'hC, 3'h0, 1'b0, 27'h0);
    op(12'h123, 12'hFFF, 4'h6, 3'h5, 1'b0, 27'h0);
    op(12'h801, 12'h003, 4'hF, 3'h0, 1'b0, 27'h0);
    op(12'h0AB, 12'h0CD, 4'h1, 3'h2, 1'b0, 27'h0);
    op(12'h111, 12'h222, 4'h2, 3'h7, 1'b1, 27'h5A5A5A5);
    op(12'h333, 12'h044, 4'h2, 3'h5, 1'b1, 27'h2C3E1F0);
    op(12'h456, 12'h789, 4'h3, 3'h6, 1'b1, 27'h1234567);
    op(12'hF00, 12'h00F, 4'h7, 3'h0, 1'b0, 27'h0);
    repeat (40) begin
      r1 = $random(seed);
      r2 = $random(seed);
      r3 = $random(seed);
      op(r1[11:0], r1[23:12], r2[3:0], r2[6:4], r2[8:7] == 2'b00, r3[26:0]);
    end
    finish_test();
  end
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
endmodule : mac12_accumulate_preload_bench
`default_nettype wire
